// ==== include/glc_pkg.sv ====
package glc_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LEDS = 8'h08;
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_FB_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Actuator position thresholds, smaller is deeper in the head.
  localparam logic [7:0] ACT_SAFE_LIMIT = 8'h40;
  localparam logic [7:0] ACT_LIMIT_AREA = 8'h50;
  localparam logic [7:0] ACT_LOCKED_LIMIT = 8'h70;

  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_NSEC = 10;
  localparam int COHERENCE_TIME_NSEC = 500;
  localparam int OUT_CHECK_TIME_NSEC = 1000;
  localparam int POWER_ON_TIME_US = 2000;
  localparam int TEST_PERIOD_US = 10000;
  localparam int FAST_FLASH_US = 100000;
  localparam int SLOW_FLASH_US = 500000;
  localparam int FB_TIME_US = 300000;
  localparam int COHERENCE_CYC = COHERENCE_TIME_NSEC / CLK_PERIOD_NSEC;
  localparam int OUT_CHECK_CYC = OUT_CHECK_TIME_NSEC / CLK_PERIOD_NSEC;
  localparam int POWER_ON_CYC = (POWER_ON_TIME_US * 1000 + CLK_PERIOD_NSEC - 1) / CLK_PERIOD_NSEC;
  localparam int TEST_PERIOD_CYC = TEST_PERIOD_US * 1000 / CLK_PERIOD_NSEC;
  localparam int FAST_FLASH_CYC = FAST_FLASH_US * 1000 / CLK_PERIOD_NSEC;
  localparam int SLOW_FLASH_CYC = SLOW_FLASH_US * 1000 / CLK_PERIOD_NSEC;
  localparam int FB_CYC = FB_TIME_US * 1000 / CLK_PERIOD_NSEC;

  // ==========================================================================
  // Device states.
  typedef enum logic [2:0] {
    GLC_ST_POWER_ON = 3'b001,
    GLC_ST_RUN = 3'b010,
    GLC_ST_ERROR = 3'b100
  } glc_state_t;

endpackage

// ==== design/glc_guard_lock.sv ====
`timescale 1ns/1ps

module glc_guard_lock #(
  parameter int unsigned POWER_ON_CYC = glc_pkg::POWER_ON_CYC,
  parameter int unsigned TEST_PERIOD_CYC = glc_pkg::TEST_PERIOD_CYC,
  parameter int unsigned FAST_FLASH_CYC = glc_pkg::FAST_FLASH_CYC,
  parameter int unsigned SLOW_FLASH_CYC = glc_pkg::SLOW_FLASH_CYC,
  parameter int unsigned FB_CYC = glc_pkg::FB_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic safety_in_a_i,
  input wire logic safety_in_b_i,
  input wire logic lock_cmd_a_i,
  input wire logic lock_cmd_b_i,
  input wire logic relay_feedback_i,
  input wire logic act_valid_i,
  input wire logic [7:0] act_pos_i,
  input wire logic act_detect_fault_i,
  input wire logic aux_release_i,
  input wire logic out_sense_a_i,
  input wire logic out_sense_b_i,
  input wire logic internal_fault_i,
  input wire logic supply_high_i,
  input wire logic supply_tol_i,
  output logic safety_out_a_o,
  output logic safety_out_b_o,
  output logic door_closed_flag_out_o,
  output logic door_locked_flag_out_o,
  output logic lock_drive_o,
  output logic power_indicator_o,
  output logic inputs_indicator_o,
  output logic outputs_indicator_o,
  output logic actuator_present_indicator_o,
  output logic lock_indicator_o,
  output logic relay_feedback_indicator_o
);
  import glc_pkg::*;

  // ==========================================================================
  // State declarations.
  glc_state_t state_reg, state_next;
  logic [1:0] ctrl_reg, ctrl_next, bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0] awaddr_reg, awaddr_next, in_coh_cnt_reg, in_coh_cnt_next;
  logic [7:0] lk_coh_cnt_reg, lk_coh_cnt_next, out_chk_cnt_reg, out_chk_cnt_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next, timer_reg, timer_next;
  logic [31:0] test_cnt_reg, test_cnt_next, flash_cnt_reg, flash_cnt_next;
  logic [31:0] fb_cnt_reg, fb_cnt_next;
  logic restart_reg, restart_next, aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic wstrb0_reg, wstrb0_next, bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic flash_fast_reg, flash_fast_next, flash_slow_reg, flash_slow_next;
  logic in_incoh_reg, in_incoh_next, lk_incoh_reg, lk_incoh_next;
  logic present_reg, present_next, locked_reg, locked_next, out_en_reg, out_en_next;
  logic err_out_reg, err_out_next, err_det_reg, err_det_next, err_int_reg, err_int_next;
  logic err_fb_reg, err_fb_next, closed_reg, closed_next, door_lk_reg, door_lk_next;
  logic [5:0] leds_reg, leds_next;

  logic wr_fire, rd_fire, run, inputs_ok, lock_ok, out_mismatch, test_tick;
  logic [7:0] area_limit;
  logic [31:0] status_word;

  // ==========================================================================
  // AXI4-Lite slave.
  assign s_axi_awready_o = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready_o = !w_held_reg && !bvalid_reg;
  assign s_axi_arready_o = !rvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rresp_o = rresp_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign wr_fire = aw_held_reg && w_held_reg;
  assign rd_fire = s_axi_arvalid_i && !rvalid_reg;

  assign status_word = {8'h00, 2'h0, lk_incoh_reg, in_incoh_reg, err_fb_reg, err_int_reg,
                        err_det_reg, err_out_reg, 2'h0, aux_release_i, present_reg, locked_reg,
                        out_en_reg, door_lk_reg, closed_reg, 5'h00, state_reg};

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    ctrl_next = ctrl_reg;
    restart_next = 1'b0;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata_i;
      wstrb0_next = s_axi_wstrb_i[0];
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      unique case ({awaddr_reg[7:2], 2'b00})
        ADDR_CTRL: begin
          if (wstrb0_reg) begin
            ctrl_next = {wdata_reg[CTRL_FB_BIT], wdata_reg[CTRL_MODE_BIT]};
            restart_next = wdata_reg[CTRL_RESTART_BIT];
          end
        end
        ADDR_STATUS, ADDR_LEDS: bresp_next = RESP_OKAY;
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready_i) bvalid_next = 1'b0;
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      unique case ({s_axi_araddr_i[7:2], 2'b00})
        ADDR_CTRL: rdata_next = {30'h0000_0000, ctrl_reg};
        ADDR_STATUS: rdata_next = status_word;
        ADDR_LEDS: rdata_next = {26'h000_0000, leds_reg};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg <= CTRL_RESET;
      restart_reg <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctrl_reg <= ctrl_next;
      restart_reg <= restart_next;
    end
  end

  // ==========================================================================
  // Safety control.
  assign run = (state_reg == GLC_ST_RUN);
  assign inputs_ok = safety_in_a_i && safety_in_b_i && !in_incoh_reg;
  assign lock_ok = lock_cmd_a_i && lock_cmd_b_i;
  assign area_limit = locked_reg ? ACT_LOCKED_LIMIT : ACT_LIMIT_AREA;
  assign out_mismatch = (out_sense_a_i != out_en_reg) || (out_sense_b_i != out_en_reg);
  assign test_tick = (test_cnt_reg == 32'h0000_0000);

  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    test_cnt_next = test_tick ? TEST_PERIOD_CYC - 1 : test_cnt_reg - 32'h0000_0001;
    in_coh_cnt_next = 8'h00;
    lk_coh_cnt_next = 8'h00;
    in_incoh_next = in_incoh_reg;
    lk_incoh_next = lk_incoh_reg;
    out_chk_cnt_next = 8'h00;
    fb_cnt_next = (fb_cnt_reg != 32'h0000_0000) ? fb_cnt_reg - 32'h0000_0001 : fb_cnt_reg;
    err_out_next = err_out_reg;
    err_det_next = err_det_reg;
    err_int_next = err_int_reg;
    err_fb_next = err_fb_reg;
    // Disagreement must last the coherence time before it is flagged.
    if (safety_in_a_i != safety_in_b_i) begin
      in_coh_cnt_next = (in_coh_cnt_reg < 8'(COHERENCE_CYC)) ? in_coh_cnt_reg + 8'h01 :
                        in_coh_cnt_reg;
      if (in_coh_cnt_reg >= 8'(COHERENCE_CYC)) in_incoh_next = 1'b1;
    end else if (!safety_in_a_i) begin
      in_incoh_next = 1'b0;
    end
    if (lock_cmd_a_i != lock_cmd_b_i) begin
      lk_coh_cnt_next = (lk_coh_cnt_reg < 8'(COHERENCE_CYC)) ? lk_coh_cnt_reg + 8'h01 :
                        lk_coh_cnt_reg;
      if (lk_coh_cnt_reg >= 8'(COHERENCE_CYC)) lk_incoh_next = 1'b1;
    end else begin
      lk_incoh_next = 1'b0;
    end
    // Present: entry needs the safe area, exit once past the (widened) limit.
    present_next = act_valid_i && (present_reg ? (act_pos_i <= area_limit) :
                   (act_pos_i <= ACT_SAFE_LIMIT));
    locked_next = run && present_next && lock_ok && !lk_incoh_next && !aux_release_i;
    out_en_next = run && inputs_ok && present_next &&
                  (ctrl_reg[CTRL_MODE_BIT] || locked_next);
    closed_next = run && present_next;
    door_lk_next = run && present_next && locked_next;
    // Relay feedback is high while the relay is released, so it must oppose the outputs.
    if (out_en_next != out_en_reg) fb_cnt_next = FB_CYC;
    if (out_mismatch) begin
      out_chk_cnt_next = (out_chk_cnt_reg < 8'(OUT_CHECK_CYC)) ? out_chk_cnt_reg + 8'h01 :
                         out_chk_cnt_reg;
    end
    unique case (state_reg)
      GLC_ST_POWER_ON: begin
        timer_next = timer_reg + 32'h0000_0001;
        if (internal_fault_i) err_int_next = 1'b1;
        if (out_sense_a_i || out_sense_b_i) err_out_next = 1'b1;
        if (act_detect_fault_i) err_det_next = 1'b1;
        if (err_int_next || err_out_next || err_det_next) begin
          state_next = GLC_ST_ERROR;
        end else if (timer_reg >= POWER_ON_CYC - 1) begin
          state_next = GLC_ST_RUN;
        end
      end
      GLC_ST_RUN: begin
        if (out_chk_cnt_reg >= 8'(OUT_CHECK_CYC)) err_out_next = 1'b1;
        if (act_detect_fault_i) err_det_next = 1'b1;
        if (internal_fault_i && test_tick) err_int_next = 1'b1;
        if (ctrl_reg[CTRL_FB_BIT] && fb_cnt_reg == 32'h0000_0001 &&
            relay_feedback_i == out_en_reg) begin
          err_fb_next = 1'b1;
        end
        if (err_out_next || err_det_next || err_int_next || err_fb_next) begin
          state_next = GLC_ST_ERROR;
        end
      end
      GLC_ST_ERROR: begin
        // Only a restart leaves; the power-on tests catch a remaining output, detection or internal fault.
        if (restart_reg) begin
          state_next = GLC_ST_POWER_ON;
          timer_next = 32'h0000_0000;
          err_out_next = 1'b0;
          err_det_next = 1'b0;
          err_int_next = 1'b0;
          err_fb_next = 1'b0;
        end
      end
    endcase
    if (state_next != GLC_ST_RUN) begin
      out_en_next = 1'b0;
      closed_next = 1'b0;
      door_lk_next = 1'b0;
      locked_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= GLC_ST_POWER_ON;
      timer_reg <= 32'h0000_0000;
      test_cnt_reg <= 32'h0000_0000;
      in_coh_cnt_reg <= 8'h00;
      lk_coh_cnt_reg <= 8'h00;
      out_chk_cnt_reg <= 8'h00;
      fb_cnt_reg <= 32'h0000_0000;
      in_incoh_reg <= 1'b0;
      lk_incoh_reg <= 1'b0;
      present_reg <= 1'b0;
      locked_reg <= 1'b0;
      out_en_reg <= 1'b0;
      closed_reg <= 1'b0;
      door_lk_reg <= 1'b0;
      err_out_reg <= 1'b0;
      err_det_reg <= 1'b0;
      err_int_reg <= 1'b0;
      err_fb_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      test_cnt_reg <= test_cnt_next;
      in_coh_cnt_reg <= in_coh_cnt_next;
      lk_coh_cnt_reg <= lk_coh_cnt_next;
      out_chk_cnt_reg <= out_chk_cnt_next;
      fb_cnt_reg <= fb_cnt_next;
      in_incoh_reg <= in_incoh_next;
      lk_incoh_reg <= lk_incoh_next;
      present_reg <= present_next;
      locked_reg <= locked_next;
      out_en_reg <= out_en_next;
      closed_reg <= closed_next;
      door_lk_reg <= door_lk_next;
      err_out_reg <= err_out_next;
      err_det_reg <= err_det_next;
      err_int_reg <= err_int_next;
      err_fb_reg <= err_fb_next;
    end
  end

  assign safety_out_a_o = out_en_reg;
  assign safety_out_b_o = out_en_reg;
  assign door_closed_flag_out_o = closed_reg;
  assign door_locked_flag_out_o = door_lk_reg;
  assign lock_drive_o = locked_reg;

  // ==========================================================================
  // Indicators.
  always_comb begin
    flash_cnt_next = flash_cnt_reg + 32'h0000_0001;
    flash_fast_next = flash_fast_reg;
    flash_slow_next = flash_slow_reg;
    if (flash_cnt_reg % FAST_FLASH_CYC == FAST_FLASH_CYC - 1) flash_fast_next = !flash_fast_reg;
    if (flash_cnt_reg >= SLOW_FLASH_CYC - 1) begin
      flash_cnt_next = 32'h0000_0000;
      flash_slow_next = !flash_slow_reg;
    end
    // Order: power, inputs, outputs, actuator, lock, feedback.
    leds_next[0] = supply_high_i ? flash_fast_reg :
                   supply_tol_i ? flash_slow_reg : 1'b1;
    leds_next[1] = in_incoh_reg ? flash_fast_reg : inputs_ok;
    leds_next[2] = out_en_reg;
    leds_next[3] = present_reg;
    leds_next[4] = (lk_incoh_reg || aux_release_i) ? flash_fast_reg : locked_reg;
    leds_next[5] = relay_feedback_i;
    unique case (state_reg)
      GLC_ST_POWER_ON: leds_next = 6'h3F;
      GLC_ST_RUN: ;
      GLC_ST_ERROR: begin
        leds_next = {err_fb_reg & flash_fast_reg, 1'b0, err_det_reg & flash_fast_reg,
                     err_out_reg & flash_fast_reg, 1'b0, err_int_reg ? flash_fast_reg : 1'b1};
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flash_cnt_reg <= 32'h0000_0000;
      flash_fast_reg <= 1'b0;
      flash_slow_reg <= 1'b0;
      leds_reg <= 6'h00;
    end else begin
      flash_cnt_reg <= flash_cnt_next;
      flash_fast_reg <= flash_fast_next;
      flash_slow_reg <= flash_slow_next;
      leds_reg <= leds_next;
    end
  end

  assign power_indicator_o = leds_reg[0];
  assign inputs_indicator_o = leds_reg[1];
  assign outputs_indicator_o = leds_reg[2];
  assign actuator_present_indicator_o = leds_reg[3];
  assign lock_indicator_o = leds_reg[4];
  assign relay_feedback_indicator_o = leds_reg[5];

endmodule

// ==== dv/glc_guard_lock_properties.sv ====
`timescale 1ns/1ps
module glc_guard_lock_properties (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic safety_in_a_i,
  input wire logic safety_in_b_i,
  input wire logic lock_cmd_a_i,
  input wire logic lock_cmd_b_i,
  input wire logic act_valid_i,
  input wire logic aux_release_i,
  input wire logic safety_out_a_o,
  input wire logic safety_out_b_o,
  input wire logic door_closed_flag_out_o,
  input wire logic door_locked_flag_out_o,
  input wire logic lock_drive_o
);
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_unlock;
    !(lock_cmd_a_i && lock_cmd_b_i);
  endsequence
  sequence s_lock_gone;
    !door_locked_flag_out_o && !lock_drive_o;
  endsequence
  property p_out_pair;
    safety_out_a_o == safety_out_b_o;
  endproperty
  property p_need_in;
    safety_out_a_o |-> $past(safety_in_a_i && safety_in_b_i);
  endproperty
  property p_need_present;
    safety_out_a_o |-> door_closed_flag_out_o;
  endproperty
  property p_lock_present;
    door_locked_flag_out_o |-> door_closed_flag_out_o;
  endproperty
  property p_close_cause;
    $rose(door_closed_flag_out_o) |-> $past(act_valid_i);
  endproperty
  property p_loss;
    !act_valid_i |=> !door_closed_flag_out_o && !safety_out_a_o;
  endproperty
  property p_aux;
    aux_release_i && !lock_drive_o |=> !lock_drive_o;
  endproperty
  property p_unlock;
    s_unlock |=> s_lock_gone;
  endproperty
  a_out_pair: assert property (p_out_pair) else $error("outputs differ");
  a_need_in: assert property (p_need_in) else $error("output without inputs");
  a_need_present: assert property (p_need_present) else $error("output w/o actuator");
  a_lock_present: assert property (p_lock_present) else $error("locked w/o closed");
  a_close_cause: assert property (p_close_cause) else $error("closed w/o actuator");
  a_loss: assert property (p_loss) else $error("actuator loss ignored");
  a_aux: assert property (p_aux) else $error("locked during release");
  a_unlock: assert property (p_unlock) else $error("unlock ignored");
endmodule

// ==== dv/glc_partner_model.sv ====
`timescale 1ns/1ps
module glc_partner_model (
  input wire logic clk_sys_i,
  input wire logic safety_out_a_i,
  input wire logic safety_out_b_i,
  input wire logic short_i,
  input wire logic stuck_i,
  output logic out_sense_a_o,
  output logic out_sense_b_o,
  output logic relay_feedback_o
);
  // Readback follows the outputs unless a short to supply is imitated.
  assign out_sense_a_o = short_i | safety_out_a_i;
  assign out_sense_b_o = short_i | safety_out_b_i;
  // Guided contact is high while the relay driven by the outputs is released.
  always_ff @(posedge clk_sys_i) begin
    relay_feedback_o <= stuck_i | !(safety_out_a_i | safety_out_b_i);
  end
endmodule

// ==== dv/glc_guard_lock_tb_top.sv ====
`timescale 1ns/1ps
module glc_guard_lock_tb_top;
  import glc_pkg::*;
  localparam int POC = 20;
  logic clk_sys_i = '0, rstn_i = '0, stuck = '0;
  logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0, act_pos_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, v;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic s_axi_awvalid_i = '0, s_axi_wvalid_i = '0, s_axi_bready_i = '0;
  logic s_axi_arvalid_i = '0, s_axi_rready_i = '0, safety_in_a_i = '0, safety_in_b_i = '0;
  logic lock_cmd_a_i = '0, lock_cmd_b_i = '0, act_valid_i = '0, aux_release_i = '0;
  logic supply_high_i = '0, supply_tol_i = '0;
  logic [2:0] flt = '0;
  wire logic internal_fault_i = flt[2];
  wire logic act_detect_fault_i = flt[1];
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic safety_out_a_o, safety_out_b_o, door_closed_flag_out_o, door_locked_flag_out_o;
  logic lock_drive_o, power_indicator_o, inputs_indicator_o, outputs_indicator_o;
  logic actuator_present_indicator_o, lock_indicator_o, relay_feedback_indicator_o;
  logic out_sense_a_i, out_sense_b_i, relay_feedback_i;
  int n_mismatch = 0, total_checks = 0, tmo = 0;

  glc_guard_lock #(.POWER_ON_CYC(POC), .TEST_PERIOD_CYC(16), .FAST_FLASH_CYC(4),
    .SLOW_FLASH_CYC(16), .FB_CYC(20)) glc_guard_lock_inst (.clk_sys_i, .rstn_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .safety_in_a_i, .safety_in_b_i, .lock_cmd_a_i,
    .lock_cmd_b_i, .relay_feedback_i, .act_valid_i, .act_pos_i, .act_detect_fault_i,
    .aux_release_i, .out_sense_a_i, .out_sense_b_i, .internal_fault_i, .supply_high_i,
    .supply_tol_i, .safety_out_a_o, .safety_out_b_o, .door_closed_flag_out_o,
    .door_locked_flag_out_o, .lock_drive_o, .power_indicator_o, .inputs_indicator_o,
    .outputs_indicator_o, .actuator_present_indicator_o, .lock_indicator_o,
    .relay_feedback_indicator_o);
  glc_partner_model glc_partner_model_inst (.clk_sys_i, .safety_out_a_i(safety_out_a_o),
    .safety_out_b_i(safety_out_b_o), .short_i(flt[0]), .stuck_i(stuck),
    .out_sense_a_o(out_sense_a_i), .out_sense_b_o(out_sense_b_i),
    .relay_feedback_o(relay_feedback_i));

  always #5 clk_sys_i = !clk_sys_i;

  task automatic report_and_stop;
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    tmo++;
    if (tmo == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    do begin
      @(negedge clk_sys_i);
      aw = s_axi_awready_o;
      w = s_axi_wready_o;
      b = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge clk_sys_i);
      if (aw) s_axi_awvalid_i <= 1'h0;
      if (w) s_axi_wvalid_i <= 1'h0;
    end while (b !== 1'h1);
    s_axi_bready_i <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, rv;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do begin
      @(negedge clk_sys_i);
      ar = s_axi_arready_o;
      rv = s_axi_rvalid_o;
      v = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge clk_sys_i);
      if (ar) s_axi_arvalid_i <= 1'h0;
    end while (rv !== 1'h1);
    s_axi_rready_i <= 1'h0;
  endtask

  initial begin
    cyc(16);
    rstn_i <= 1'h1;
    rd(ADDR_STATUS);
    chk(v[2:0], 3'h1);
    cyc(POC);
    rd(ADDR_STATUS);
    chk(v[2:0], 3'h2);
    rd(8'h0c);
    chk(v, 32'h0000_0000);
    chk(r, RESP_SLVERR);
    wr(8'h10, 32'h0000_0000);
    chk(r, RESP_SLVERR);
    act_valid_i <= 1'h1;
    act_pos_i <= ACT_SAFE_LIMIT;
    safety_in_a_i <= 1'h1;
    safety_in_b_i <= 1'h1;
    cyc(4);
    chk({door_closed_flag_out_o, actuator_present_indicator_o, safety_out_a_o}, 3'h6);
    lock_cmd_a_i <= 1'h1;
    lock_cmd_b_i <= 1'h1;
    cyc(4);
    chk({safety_out_a_o, safety_out_b_o, door_locked_flag_out_o}, 3'h7);
    chk({power_indicator_o, inputs_indicator_o, lock_indicator_o}, 3'h7);
    rd(ADDR_LEDS);
    chk(v, 32'h0000_001f);
    supply_high_i <= 1'h1;
    cyc(3);
    v[0] = power_indicator_o;
    cyc(4);
    chk(power_indicator_o, !v[0]);
    supply_high_i <= 1'h0;
    supply_tol_i <= 1'h1;
    cyc(3);
    v[0] = power_indicator_o;
    cyc(16);
    chk(power_indicator_o, !v[0]);
    supply_tol_i <= 1'h0;
    act_pos_i <= 8'h60;
    cyc(4);
    chk({door_closed_flag_out_o, safety_out_a_o}, 2'h3);
    lock_cmd_a_i <= 1'h0;
    lock_cmd_b_i <= 1'h0;
    cyc(4);
    chk({safety_out_a_o, outputs_indicator_o, door_locked_flag_out_o}, 3'h0);
    chk(door_closed_flag_out_o, 1'h0);
    wr(ADDR_CTRL, 32'h0000_0001);
    act_pos_i <= ACT_SAFE_LIMIT;
    cyc(4);
    chk({safety_out_a_o, door_locked_flag_out_o}, 2'h2);
    safety_in_b_i <= 1'h0;
    cyc(60);
    rd(ADDR_STATUS);
    chk({v[20], safety_out_a_o}, 2'h2);
    safety_in_a_i <= 1'h0;
    cyc(3);
    rd(ADDR_STATUS);
    chk(v[20], 1'h0);
    safety_in_a_i <= 1'h1;
    safety_in_b_i <= 1'h1;
    cyc(4);
    chk(safety_out_a_o, 1'h1);
    act_valid_i <= 1'h0;
    cyc(3);
    chk({safety_out_a_o, door_closed_flag_out_o, actuator_present_indicator_o}, 3'h0);
    act_valid_i <= 1'h1;
    lock_cmd_a_i <= 1'h1;
    cyc(60);
    rd(ADDR_STATUS);
    chk({v[21], lock_drive_o}, 2'h2);
    lock_cmd_a_i <= 1'h0;
    cyc(3);
    rd(ADDR_STATUS);
    chk(v[21], 1'h0);
    aux_release_i <= 1'h1;
    lock_cmd_a_i <= 1'h1;
    lock_cmd_b_i <= 1'h1;
    cyc(5);
    rd(ADDR_STATUS);
    chk({v[13], lock_drive_o, door_locked_flag_out_o}, 3'h4);
    aux_release_i <= 1'h0;
    cyc(4);
    chk(lock_drive_o, 1'h1);
    lock_cmd_a_i <= 1'h0;
    lock_cmd_b_i <= 1'h0;
    wr(ADDR_CTRL, 32'h0000_0003);
    rd(ADDR_CTRL);
    chk(v, 32'h0000_0003);
    cyc(40);
    rd(ADDR_STATUS);
    chk({v[2:0], relay_feedback_indicator_o}, 4'h4);
    stuck <= 1'h1;
    act_valid_i <= 1'h0;
    cyc(4);
    act_valid_i <= 1'h1;
    cyc(40);
    rd(ADDR_STATUS);
    chk({v[19], v[2:0], safety_out_a_o}, 5'h18);
    stuck <= 1'h0;
    wr(ADDR_CTRL, 32'h0000_0004);
    cyc(POC + 10);
    for (int k = 0; k < 3; k++) begin
      flt <= 3'h1 << k;
      cyc(150);
      rd(ADDR_STATUS);
      chk({v[18:16], v[2:0]}, {3'h1 << k, 3'h4});
      chk({door_closed_flag_out_o, safety_out_a_o}, 2'h0);
      wr(ADDR_CTRL, 32'h0000_0004);
      cyc(POC + 10);
      rd(ADDR_STATUS);
      chk(v[2:0], 3'h4);
      flt <= 3'h0;
      wr(ADDR_CTRL, 32'h0000_0004);
      cyc(POC + 10);
      rd(ADDR_STATUS);
      chk(v[2:0], 3'h2);
    end
    report_and_stop();
  end
endmodule

bind glc_guard_lock glc_guard_lock_properties glc_guard_lock_properties_inst (.clk_sys_i,
  .rstn_i, .safety_in_a_i, .safety_in_b_i, .lock_cmd_a_i, .lock_cmd_b_i, .act_valid_i,
  .aux_release_i, .safety_out_a_o, .safety_out_b_o, .door_closed_flag_out_o,
  .door_locked_flag_out_o, .lock_drive_o);
